// [lpu_core.sv]
// Serial port core: APB registers, command decode, shifters and status flags
`timescale 1ns/10ps
module lpu_core
  import lpu_pkg::*;
#(
  parameter int DEPTH = LPU_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin
);
  initial if (DEPTH < 2) $error("DEPTH too small");

  typedef enum logic [1:0] {LPU_TX_IDLE, LPU_TX_SHIFT} lpu_tx_e;
  typedef enum logic [1:0] {LPU_RX_IDLE, LPU_RX_START, LPU_RX_DATA, LPU_RX_STOP} lpu_rx_e;

  lpu_stream_if #(.W(LPU_DATA_W)) tx_in ();
  lpu_stream_if #(.W(LPU_DATA_W)) tx_out ();
  lpu_stream_if #(.W(LPU_DATA_W)) rx_in ();
  lpu_stream_if #(.W(LPU_DATA_W)) rx_out ();

  // Control and status state
  logic receiver_on_state;
  logic transmitter_on_state;
  logic rx_discard_state;
  logic tx_complete;
  logic [15:0] baud;
  logic tx_empty;
  logic tx_full;
  logic rx_empty;
  logic rx_full;
  logic [31:0] prdata_q;
  logic rd_done;

  // APB decode; writes finish at once, reads take one wait state
  // so that the registered read data stands at the edge pready is high
  wire apb_acc = psel && penable;
  wire wr_en = apb_acc && pwrite && ce;
  wire rd_en = apb_acc && !pwrite && ce && !rd_done;
  wire hit_cmd = (paddr == LPU_OFS_COMMAND);
  wire hit_status = (paddr == LPU_OFS_STATUS);
  wire hit_txd = (paddr == LPU_OFS_TXDATA);
  wire hit_rxd = (paddr == LPU_OFS_RXDATA);
  wire hit_baud = (paddr == LPU_OFS_BAUD);
  wire hit_any = hit_cmd || hit_status || hit_txd || hit_rxd || hit_baud;
  assign pready = !(apb_acc && !pwrite) || rd_done;
  assign pslverr = apb_acc && !hit_any;
  assign prdata = prdata_q;

  // Command pulses; bits 31:8 are ignored, software keeps them zero
  wire cmd_wr = wr_en && hit_cmd;
  wire rx_on_cmd = cmd_wr && pwdata[LPU_CMD_RECEIVER_ON_CMD];
  wire receiver_off_cmd = cmd_wr && pwdata[LPU_CMD_RECEIVER_OFF_CMD];
  wire transmitter_on_cmd = cmd_wr && pwdata[LPU_CMD_TRANSMITTER_ON_CMD];
  wire transmitter_off_cmd = cmd_wr && pwdata[LPU_CMD_TRANSMITTER_OFF_CMD];
  wire rx_discard_on_cmd = cmd_wr && pwdata[LPU_CMD_BLKEN];
  wire rx_discard_off_cmd = cmd_wr && pwdata[LPU_CMD_BLKDIS];
  wire tx_path_clear = cmd_wr && pwdata[LPU_CMD_TXCLR];
  wire rx_path_clear = cmd_wr && pwdata[LPU_CMD_RXCLR];

  // Status word
  wire [31:0] status_word = {26'h0, !rx_empty, tx_empty, tx_complete,
                             rx_discard_state, transmitter_on_state, receiver_on_state};

  // Read mux; reading data pops the receive FIFO
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_rxd ? {24'h0, rx_out.data} :
                       hit_baud ? {16'h0, baud} : 32'h0;
  assign rx_out.ready = rd_en && hit_rxd;
  assign tx_in.valid = wr_en && hit_txd;
  assign tx_in.data = pwdata[7:0];

  // Read data register, loaded during the access cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_q <= 32'h0;
    else if (ce && psel && !penable)
      prdata_q <= 32'h0;
    else if (rd_en)
      prdata_q <= rd_mux;

  // Read wait state: data loads at the first access edge, pready rises after
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rd_done <= 1'b0;
    else if (ce)
      rd_done <= rd_en;

  // Bit time register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      baud <= LPU_BAUD_RESET;
    else if (wr_en && hit_baud)
      baud <= pwdata[15:0];

  // Enable and blocking flags; disable wins if both bits are written together
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      receiver_on_state <= 1'b0;
      transmitter_on_state <= 1'b0;
      rx_discard_state <= 1'b0;
    end
    else if (ce)
    begin
      if (receiver_off_cmd)
        receiver_on_state <= 1'b0;
      else if (rx_on_cmd)
        receiver_on_state <= 1'b1;
      if (transmitter_off_cmd)
        transmitter_on_state <= 1'b0;
      else if (transmitter_on_cmd)
        transmitter_on_state <= 1'b1;
      if (rx_discard_off_cmd)
        rx_discard_state <= 1'b0;
      else if (rx_discard_on_cmd)
        rx_discard_state <= 1'b1;
    end

  // Transmit FIFO, flushed by the transmit clear command
  lpu_fifo #(.W(LPU_DATA_W), .DEPTH(DEPTH)) u_txf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .flush(tx_path_clear),
    .in_s(tx_in),
    .out_s(tx_out),
    .empty(tx_empty),
    .full(tx_full)
  );

  // Receive FIFO, flushed by the receive clear command
  lpu_fifo #(.W(LPU_DATA_W), .DEPTH(DEPTH)) u_rxf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .flush(rx_path_clear),
    .in_s(rx_in),
    .out_s(rx_out),
    .empty(rx_empty),
    .full(rx_full)
  );

  // Transmitter: start, 8 data bits LSB first, one stop bit
  lpu_tx_e tx_st;
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  logic [15:0] tx_cnt;
  wire tx_tick = (tx_cnt == 16'h0);
  wire tx_start = (tx_st == LPU_TX_IDLE) && transmitter_on_state && tx_out.valid;
  wire tx_last = (tx_st == LPU_TX_SHIFT) && tx_tick && (tx_bits == 4'h0);
  assign tx_out.ready = tx_start;

  // A busy shifter is allowed to finish a frame after transmitter off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_st <= LPU_TX_IDLE;
      tx_sh <= 10'h3FF;
      tx_bits <= 4'h0;
      tx_cnt <= 16'h0;
      serial_out_pin <= 1'b1;
    end
    else if (ce)
    begin
      if (tx_path_clear)
      begin
        tx_st <= LPU_TX_IDLE;
        serial_out_pin <= 1'b1;
      end
      else if (tx_start)
      begin
        tx_st <= LPU_TX_SHIFT;
        tx_sh <= {1'b1, tx_out.data, 1'b0};
        tx_bits <= 4'h9;
        tx_cnt <= baud;
        serial_out_pin <= 1'b0;
      end
      else if (tx_st == LPU_TX_SHIFT)
      begin
        tx_cnt <= tx_tick ? baud : tx_cnt - 16'h1;
        if (tx_tick && tx_bits != 4'h0)
        begin
          tx_sh <= {1'b1, tx_sh[9:1]};
          serial_out_pin <= tx_sh[1];
          tx_bits <= tx_bits - 4'h1;
        end
        if (tx_last)
          tx_st <= LPU_TX_IDLE;
      end
    end

  // Complete flag: set at idle frame end, cleared at the next start
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_complete <= 1'b0;
    else if (ce)
    begin
      if (tx_start)
        tx_complete <= 1'b0;
      else if (tx_last && !tx_out.valid)
        tx_complete <= 1'b1;
    end

  // Receiver: samples mid-bit, drops frames on disable or clear
  lpu_rx_e rx_st;
  logic [7:0] rx_sh;
  logic [3:0] rx_bits;
  logic [15:0] rx_cnt;
  logic [7:0] rx_byte;
  logic rx_push;
  wire rx_tick = (rx_cnt == 16'h0);
  wire rx_abort = rx_path_clear || receiver_off_cmd || !receiver_on_state;
  assign rx_in.valid = rx_push;
  assign rx_in.data = rx_byte;

  // Push is single cycle; a full FIFO loses the frame
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_st <= LPU_RX_IDLE;
      rx_sh <= 8'h0;
      rx_bits <= 4'h0;
      rx_cnt <= 16'h0;
      rx_byte <= 8'h0;
      rx_push <= 1'b0;
    end
    else if (ce)
    begin
      rx_push <= 1'b0;
      if (rx_abort)
        rx_st <= LPU_RX_IDLE;
      else
        unique case (rx_st)
          LPU_RX_IDLE:
            if (!serial_in_pin)
            begin
              rx_st <= LPU_RX_START;
              rx_cnt <= {1'b0, baud[15:1]};
            end
          LPU_RX_START:
            if (!rx_tick)
              rx_cnt <= rx_cnt - 16'h1;
            else if (serial_in_pin)
              rx_st <= LPU_RX_IDLE;
            else
            begin
              rx_st <= LPU_RX_DATA;
              rx_cnt <= baud;
              rx_bits <= 4'h8;
            end
          LPU_RX_DATA:
            if (!rx_tick)
              rx_cnt <= rx_cnt - 16'h1;
            else
            begin
              rx_sh <= {serial_in_pin, rx_sh[7:1]};
              rx_cnt <= baud;
              rx_bits <= rx_bits - 4'h1;
              if (rx_bits == 4'h1)
                rx_st <= LPU_RX_STOP;
            end
          LPU_RX_STOP:
            if (!rx_tick)
              rx_cnt <= rx_cnt - 16'h1;
            else
            begin
              rx_st <= LPU_RX_IDLE;
              rx_byte <= rx_sh;
              rx_push <= serial_in_pin && !rx_discard_state;
            end
        endcase
    end
endmodule

// [lpu_pkg.sv]
// Package with register map, status layout and command fields of the serial port core
// Contract
// - Receive clear empties buffer and shifter
// - Transmit clear empties buffer and shifter
// - Discard off clears, on sets blocking
// - Receiver off drops any partial frame
// - Receiver on starts reception from pin
// - Transmitter state flag mirrors transmitter enable
// - Receiver flag; detection only while enabled
// - Buffer level one when transmit buffer empty
// - Complete set at idle end, cleared on start
// - Blocking at frame end discards frame
package lpu_pkg;
  localparam logic [11:0] LPU_OFS_COMMAND = 12'h004;
  localparam logic [11:0] LPU_OFS_STATUS = 12'h008;
  localparam logic [11:0] LPU_OFS_TXDATA = 12'h00C;
  localparam logic [11:0] LPU_OFS_RXDATA = 12'h010;
  localparam logic [11:0] LPU_OFS_BAUD = 12'h014;
  // Command bit positions
  localparam int LPU_CMD_RECEIVER_ON_CMD = 0;
  localparam int LPU_CMD_RECEIVER_OFF_CMD = 1;
  localparam int LPU_CMD_TRANSMITTER_ON_CMD = 2;
  localparam int LPU_CMD_TRANSMITTER_OFF_CMD = 3;
  localparam int LPU_CMD_BLKEN = 4;
  localparam int LPU_CMD_BLKDIS = 5;
  localparam int LPU_CMD_TXCLR = 6;
  localparam int LPU_CMD_RXCLR = 7;
  // Status bit positions
  localparam int LPU_ST_RECEIVER_ON_STATE = 0;
  localparam int LPU_ST_TRANSMITTER_ON_STATE = 1;
  localparam int LPU_ST_BLOCK = 2;
  localparam int LPU_ST_TXC = 3;
  localparam int LPU_ST_TX_BUFFER_LEVEL = 4;
  localparam int LPU_ST_RXDV = 5;
  localparam logic [31:0] LPU_STATUS_RESET = 32'h0000_0010;
  localparam int LPU_FIFO_DEPTH = 8;
  localparam int LPU_DATA_W = 8;
  // Default bit time register reset value; one bit lasts this value plus one pclk cycles
  localparam logic [15:0] LPU_BAUD_RESET = 16'h0010;
endpackage

// [lpu_stream_if.sv]
// Interface carrying one valid/ready byte stream between the core modules
`timescale 1ns/10ps
interface lpu_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [lpu_fifo.sv]
// Synchronous FIFO with valid/ready on both sides and a flush input
`timescale 1ns/10ps
module lpu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic flush,
  lpu_stream_if.snk in_s,
  lpu_stream_if.src out_s,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 2");
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;
  // Pointer difference flags, one extra bit separates full from empty
  assign empty = (wptr == rptr);
  assign full = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
  assign in_s.ready = !full && !flush;
  assign out_s.valid = !empty && !flush;
  assign out_s.data = mem[rptr[AW-1:0]];
  // Flush wins over any transfer in the same cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else if (ce)
    begin
      if (flush)
        rptr <= wptr;
      else
      begin
        if (push)
          wptr <= wptr + 1'b1;
        if (pop)
          rptr <= rptr + 1'b1;
      end
    end
  always_ff @(posedge pclk)
    if (ce && push && !flush)
      mem[wptr[AW-1:0]] <= in_s.data;
endmodule

// [lpu_sva.sv]
// Checker for command and status behaviour seen at the serial port core pins
`timescale 1ns/10ps
module lpu_sva
  import lpu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin
);
  logic rx_on, tx_on, blk, rxclr, txclr, st_rd;
  // Access decode; prdata stands from the first access edge of a read
  wire acc = psel && penable && ce;
  wire cmd_wr = acc && pwrite && paddr == LPU_OFS_COMMAND;
  wire tx_wr = acc && pwrite && paddr == LPU_OFS_TXDATA;
  wire mapped = paddr inside {LPU_OFS_COMMAND, LPU_OFS_STATUS, LPU_OFS_TXDATA,
    LPU_OFS_RXDATA, LPU_OFS_BAUD};
  // Shadow of the states; an off command wins over an on command in the same word
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {rx_on, tx_on, blk, rxclr, txclr, st_rd} <= '0;
    else
    begin
      st_rd <= acc && !pwrite && pready && paddr == LPU_OFS_STATUS;
      rxclr <= (cmd_wr && pwdata[LPU_CMD_RXCLR]) || (rxclr && serial_in_pin);
      txclr <= (cmd_wr && pwdata[LPU_CMD_TXCLR]) || (txclr && !tx_wr);
      if (cmd_wr)
      begin
        rx_on <= !pwdata[LPU_CMD_RECEIVER_OFF_CMD] && (pwdata[LPU_CMD_RECEIVER_ON_CMD] || rx_on);
        tx_on <= !pwdata[LPU_CMD_TRANSMITTER_OFF_CMD] && (pwdata[LPU_CMD_TRANSMITTER_ON_CMD] || tx_on);
        blk <= !pwdata[LPU_CMD_BLKDIS] && (pwdata[LPU_CMD_BLKEN] || blk);
      end
    end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  rx_state_a: assert property (st_rd |-> prdata[LPU_ST_RECEIVER_ON_STATE] == rx_on)
    else $error("receiver state flag wrong");
  tx_state_a: assert property (st_rd |-> prdata[LPU_ST_TRANSMITTER_ON_STATE] == tx_on)
    else $error("transmitter state flag wrong");
  discard_state_a: assert property (st_rd |-> prdata[LPU_ST_BLOCK] == blk)
    else $error("discard state flag wrong");
  rx_clear_a: assert property (st_rd && rxclr |-> !prdata[LPU_ST_RXDV])
    else $error("receive data valid after clear");
  tx_clear_a: assert property (st_rd && txclr |-> prdata[LPU_ST_TX_BUFFER_LEVEL])
    else $error("transmit buffer not empty after clear");
  tx_line_a: assert property (cmd_wr && pwdata[LPU_CMD_TXCLR] |-> ##[1:3] serial_out_pin)
    else $error("serial output not idle after clear");
  err_resp_a: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  err_only_a: assert property (pslverr |-> psel && penable && !mapped)
    else $error("error response on a mapped access");
  cover property (cmd_wr && pwdata[LPU_CMD_RECEIVER_OFF_CMD]);
  cover property (st_rd && prdata[LPU_ST_RXDV]);
  cover property (st_rd && prdata[LPU_ST_TXC]);
endmodule
bind lpu_core lpu_sva chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .serial_in_pin, .serial_out_pin);

// [lpu_peer.sv]
// Remote serial station: sends frames into the core and captures frames it sends
`timescale 1ns/10ps
module lpu_peer #(
  parameter int BIT = 17
) (
  input wire logic pclk,
  input wire logic serial_out_pin,
  output logic serial_in_pin,
  output logic [7:0] got,
  output int got_n
);
  initial
  begin
    serial_in_pin = 1'b1;
    got = 8'h00;
    got_n = 0;
  end
  // Start bit, eight bits LSB first, stop; the line rests high between frames
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++)
    begin
      serial_in_pin <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT) @(posedge pclk);
    end
  endtask
  // Sample mid bit so a slightly early edge from the core still reads right
  always @(negedge serial_out_pin)
  begin
    repeat (BIT + BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      got[i] <= serial_out_pin;
      repeat (BIT) @(posedge pclk);
    end
    got_n <= got_n + 1;
  end
endmodule

// [tb_top.sv]
// Command and status bench for the serial port core
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  import lpu_pkg::*;
  localparam int BIT = LPU_BAUD_RESET + 1;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, si, so;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] got;
  int got_n, fail_count, total_checks;
  lpu_core dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_in_pin(si), .serial_out_pin(so));
  lpu_peer #(.BIT(BIT)) peer (.pclk, .serial_out_pin(so), .serial_in_pin(si), .got, .got_n);
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // One APB transfer; read data is taken at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Command words carry one bit; reserved upper bits stay zero
  task automatic cmd(input int b);
    apb(1'b1, LPU_OFS_COMMAND, 32'h1 << b);
  endtask
  task automatic stat(input int b, input logic e);
    apb(1'b0, LPU_OFS_STATUS, 32'h0);
    `CHK("status bit", e, rd[b])
  endtask
  task automatic wait_out(input int n);
    for (int t = 0; t < 20 * BIT && got_n < n; t++)
      @(posedge pclk);
    repeat (BIT) @(posedge pclk);
  endtask
  task automatic results();
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under this span
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial
  begin
    {psel, penable, pwrite, presetn} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, LPU_OFS_STATUS, 32'h0);
    `CHK("status reset", LPU_STATUS_RESET, rd)
    apb(1'b0, 12'h0F0, 32'h0);
    // Filling with the transmitter off, then clearing, must send nothing
    for (int i = 0; i < 8; i++)
      apb(1'b1, LPU_OFS_TXDATA, 32'(i));
    stat(LPU_ST_TX_BUFFER_LEVEL, 1'b0);
    cmd(LPU_CMD_TXCLR);
    stat(LPU_ST_TX_BUFFER_LEVEL, 1'b1);
    cmd(LPU_CMD_TRANSMITTER_ON_CMD);
    stat(LPU_ST_TRANSMITTER_ON_STATE, 1'b1);
    repeat (4 * BIT) @(posedge pclk);
    `CHK("frames out", 0, got_n)
    apb(1'b1, LPU_OFS_TXDATA, 32'h5A);
    wait_out(1);
    `CHK("byte out", 8'h5A, got)
    stat(LPU_ST_TXC, 1'b1);
    apb(1'b1, LPU_OFS_TXDATA, 32'hA5);
    stat(LPU_ST_TXC, 1'b0);
    wait_out(2);
    `CHK("byte out", 8'hA5, got)
    cmd(LPU_CMD_TRANSMITTER_OFF_CMD);
    stat(LPU_ST_TRANSMITTER_ON_STATE, 1'b0);
    // Receive path: enable, data valid, pop, discard and clear
    cmd(LPU_CMD_RECEIVER_ON_CMD);
    stat(LPU_ST_RECEIVER_ON_STATE, 1'b1);
    peer.send(8'h3C);
    stat(LPU_ST_RXDV, 1'b1);
    apb(1'b0, LPU_OFS_RXDATA, 32'h0);
    `CHK("byte in", 8'h3C, rd[7:0])
    stat(LPU_ST_RXDV, 1'b0);
    cmd(LPU_CMD_BLKEN);
    stat(LPU_ST_BLOCK, 1'b1);
    peer.send(8'h11);
    stat(LPU_ST_RXDV, 1'b0);
    cmd(LPU_CMD_BLKDIS);
    stat(LPU_ST_BLOCK, 1'b0);
    peer.send(8'h22);
    stat(LPU_ST_RXDV, 1'b1);
    cmd(LPU_CMD_RXCLR);
    stat(LPU_ST_RXDV, 1'b0);
    // Receiver switched off in mid frame drops it
    fork
      peer.send(8'h33);
      begin
        repeat (3 * BIT) @(posedge pclk);
        cmd(LPU_CMD_RECEIVER_OFF_CMD);
      end
    join
    stat(LPU_ST_RECEIVER_ON_STATE, 1'b0);
    stat(LPU_ST_RXDV, 1'b0);
    peer.send(8'h44);
    stat(LPU_ST_RXDV, 1'b0);
    results();
  end
endmodule
